/* File: logic/mdc_pkg.sv */
// Package: register map, field positions, reset values and shared types of the monitor config bank
package mdc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] MDC_OFS_SYNC_GATE_CONTROL   = 12'h100;
    localparam logic [11:0] MDC_OFS_FAST_DETECT_SETUP   = 12'h104;
    localparam logic [11:0] MDC_OFS_UPPER_LIMIT_LOW     = 12'h106;
    localparam logic [11:0] MDC_OFS_UPPER_LIMIT_HIGH    = 12'h107;
    localparam logic [11:0] MDC_OFS_LOWER_LIMIT_LOW     = 12'h108;
    localparam logic [11:0] MDC_OFS_LOWER_LIMIT_HIGH    = 12'h109;
    localparam logic [11:0] MDC_OFS_OFFSET_REMOVAL_CTRL = 12'h10C;
    localparam logic [11:0] MDC_OFS_OFFSET_EST_A_LOW    = 12'h10D;
    localparam logic [11:0] MDC_OFS_OFFSET_EST_A_HIGH   = 12'h10E;
    localparam logic [11:0] MDC_OFS_OFFSET_EST_B_LOW    = 12'h10F;
    localparam logic [11:0] MDC_OFS_OFFSET_EST_B_HIGH   = 12'h110;
    localparam logic [11:0] MDC_OFS_SERIAL_OUT_CONTROL  = 12'h111;
    localparam logic [11:0] MDC_OFS_MONITOR_CONTROL     = 12'h112;
    localparam logic [11:0] MDC_OFS_WINDOW_LEN_0        = 12'h113;
    localparam logic [11:0] MDC_OFS_WINDOW_LEN_1        = 12'h114;
    localparam logic [11:0] MDC_OFS_WINDOW_LEN_2        = 12'h115;
    localparam logic [11:0] MDC_OFS_RESULT_A_0          = 12'h116;
    localparam logic [11:0] MDC_OFS_RESULT_A_1          = 12'h117;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MDC_RST_ZERO        = 8'h00;
    localparam logic [7:0] MDC_RST_SERIAL_OUT  = 8'h04;
    localparam logic [7:0] MDC_RST_WINDOW_LEN0 = 8'h40;

    // ------------------------------------------------------------------
    // Writable-bit masks; reserved bits read as zero
    // ------------------------------------------------------------------
    localparam logic [7:0] MDC_MSK_SYNC       = 8'h87;
    localparam logic [7:0] MDC_MSK_FAST       = 8'h0F;
    localparam logic [7:0] MDC_MSK_LIMIT_HIGH = 8'h1F;
    localparam logic [7:0] MDC_MSK_OFFSET     = 8'h7F;
    localparam logic [7:0] MDC_MSK_SERIAL     = 8'h7F;
    localparam logic [7:0] MDC_MSK_MONITOR    = 8'h8F;
    localparam logic [7:0] MDC_MSK_FULL       = 8'hFF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MDC_SYNC_MON_EN    = 7;
    localparam int MDC_SYNC_NEXT_ONLY = 2;
    localparam int MDC_SYNC_DIV_EN    = 1;
    localparam int MDC_SYNC_MASTER_EN = 0;
    localparam int MDC_DC_FREEZE      = 6;
    localparam int MDC_DC_BW_LSB      = 2;
    localparam int MDC_DC_PATH_EN     = 1;
    localparam int MDC_DC_MON_EN      = 0;
    localparam int MDC_SO_RMS_EN      = 6;
    localparam int MDC_SO_PEAK_EN     = 5;
    localparam int MDC_SO_CROSS_EN    = 4;
    localparam int MDC_SO_DIV_LSB     = 2;
    localparam int MDC_SO_SLEEP       = 1;
    localparam int MDC_SO_EN          = 0;
    localparam int MDC_MC_COMPLEX     = 7;
    localparam int MDC_MC_MS_MODE     = 3;
    localparam int MDC_MC_MODE_LSB    = 1;
    localparam int MDC_MC_EN          = 0;

    // ------------------------------------------------------------------
    // Serial clock divide codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MDC_DIV_UNDEF = 2'h0;
    localparam logic [1:0] MDC_DIV_BY2   = 2'h1;
    localparam logic [1:0] MDC_DIV_BY4   = 2'h2;
    localparam logic [1:0] MDC_DIV_BY8   = 2'h3;

    // ------------------------------------------------------------------
    // Shared types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        fastDetectEn;
        logic [2:0]  fastDetectMode;
        logic        dcFreeze;
        logic [3:0]  dcBandwidth;
        logic        dcPathEn;
        logic        dcMonitorEn;
        logic        rmsOutEn;
        logic        peakOutEn;
        logic        crossOutEn;
        logic        serialSleep;
        logic        serialOutEn;
        logic        complexMode;
        logic        msMode;
        logic [1:0]  monitorMode;
        logic        monitorEn;
        logic [23:0] windowLen;
    } mdc_cfg_t;

    typedef struct packed {
        logic [13:0] dcEstA;
        logic [13:0] dcEstB;
        logic [15:0] resultA;
        logic        resultValid;
    } mdc_status_t;

endpackage

/* File: logic/mdc_sync_gate.sv */
// Sync pulse gating toward the signal monitor and the clock divider
`timescale 1ns/10ps
`default_nettype none
module mdc_sync_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Sync pin
    input  wire logic syncPin,
    // Enables
    input  wire logic masterEn,
    input  wire logic monitorEn,
    input  wire logic dividerEn,
    input  wire logic nextOnly,
    // Gated pulses
    output logic      monitorSync,
    output logic      dividerSync,
    output logic      dividerAligned
);
    // ------------------------------------------------------------------
    // Pin synchroniser and edge detect
    // ------------------------------------------------------------------
    logic syncMeta_r, syncSafe_r, syncLast_r;
    logic monitorSync_nxt, dividerSync_nxt, dividerAligned_nxt;
    logic syncEdge;

    always_comb begin
        syncEdge           = syncSafe_r & ~syncLast_r;
        monitorSync_nxt    = syncEdge & masterEn & monitorEn;
        dividerSync_nxt    = syncEdge & masterEn & dividerEn;
        dividerAligned_nxt = syncEdge & masterEn & dividerEn & nextOnly;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta_r     <= 1'b0;
            syncSafe_r     <= 1'b0;
            syncLast_r     <= 1'b0;
            monitorSync    <= 1'b0;
            dividerSync    <= 1'b0;
            dividerAligned <= 1'b0;
        end else begin
            syncMeta_r     <= syncPin;
            syncSafe_r     <= syncMeta_r;
            syncLast_r     <= syncSafe_r;
            monitorSync    <= monitorSync_nxt;
            dividerSync    <= dividerSync_nxt;
            dividerAligned <= dividerAligned_nxt;
        end
    end
endmodule // mdc_sync_gate
`default_nettype wire

/* File: logic/mdc_clk_div.sv */
// Serial clock divider: one-cycle tick every 2, 4 or 8 input clocks
`timescale 1ns/10ps
`default_nettype none
module mdc_clk_div
    import mdc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic [1:0] divSel,
    input  wire logic       run,
    // Tick
    output logic            tick
);
    logic [2:0] count_r, count_nxt;
    logic [2:0] last;
    logic       tick_nxt;

    always_comb begin
        case (divSel)
            MDC_DIV_BY2: last = 3'h1;
            MDC_DIV_BY4: last = 3'h3;
            MDC_DIV_BY8: last = 3'h7;
            default:     last = 3'h0;
        endcase
        // Code 00 is undefined: the divider clears its count and never ticks
        if (!run || divSel == MDC_DIV_UNDEF) begin
            count_nxt = 3'h0;
            tick_nxt  = 1'b0;
        end else if (count_r >= last) begin
            count_nxt = 3'h0;
            tick_nxt  = 1'b1;
        end else begin
            count_nxt = count_r + 3'h1;
            tick_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 3'h0;
            tick    <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick    <= tick_nxt;
        end
    end
endmodule // mdc_clk_div
`default_nettype wire

/* File: logic/mdc_regs.sv */
// Monitor, fast-detect and dc-correction configuration and result register bank
`timescale 1ns/10ps
`default_nettype none
module mdc_regs
    import mdc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic                 regWrEn,
    input  wire logic [11:0]          regAddr,
    input  wire logic [7:0]           regWrData,
    output logic [7:0]                regRdData,
    // Sync pin
    input  wire logic                 syncPin,
    // Datapath inputs
    input  wire logic [12:0]          sampleMag,
    input  wire mdc_pkg::mdc_status_t status,
    // Configuration out
    output mdc_pkg::mdc_cfg_t         cfg,
    // Events out
    output logic                      upperLimitFlag,
    output logic                      lowerLimitFlag,
    output logic                      monitorSync,
    output logic                      dividerSync,
    output logic                      monitorSerialClockTick
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]  syncCtrl_r,   syncCtrl_nxt;
    logic [7:0]  fastSetup_r,  fastSetup_nxt;
    logic [7:0]  upperLow_r,   upperLow_nxt;
    logic [7:0]  upperHigh_r,  upperHigh_nxt;
    logic [7:0]  lowerLow_r,   lowerLow_nxt;
    logic [7:0]  lowerHigh_r,  lowerHigh_nxt;
    logic [7:0]  dcCtrl_r,     dcCtrl_nxt;
    logic [7:0]  serialCtrl_r, serialCtrl_nxt;
    logic [7:0]  monCtrl_r,    monCtrl_nxt;
    logic [7:0]  window0_r,    window0_nxt;
    logic [7:0]  window1_r,    window1_nxt;
    logic [7:0]  window2_r,    window2_nxt;
    logic [13:0] dcEstA_r,     dcEstA_nxt;
    logic [13:0] dcEstB_r,     dcEstB_nxt;
    logic [15:0] resultA_r,    resultA_nxt;
    logic [7:0]  regRdData_nxt;
    logic        upperFlag_nxt, lowerFlag_nxt;
    logic        dividerAligned;
    logic        tickRaw;
    logic [12:0] upperLimit, lowerLimit;

    // ------------------------------------------------------------------
    // Sync gating and serial clock divider
    // ------------------------------------------------------------------
    mdc_sync_gate u_sync_gate (
        .clk            (clk),
        .rst_n          (rst_n),
        .syncPin        (syncPin),
        .masterEn       (syncCtrl_r[MDC_SYNC_MASTER_EN]),
        .monitorEn      (syncCtrl_r[MDC_SYNC_MON_EN]),
        .dividerEn      (syncCtrl_r[MDC_SYNC_DIV_EN]),
        .nextOnly       (syncCtrl_r[MDC_SYNC_NEXT_ONLY]),
        .monitorSync    (monitorSync),
        .dividerSync    (dividerSync),
        .dividerAligned (dividerAligned)
    );

    mdc_clk_div u_clk_div (
        .clk    (clk),
        .rst_n  (rst_n),
        .divSel (serialCtrl_r[MDC_SO_DIV_LSB +: 2]),
        .run    (serialCtrl_r[MDC_SO_EN]),
        .tick   (tickRaw)
    );

    // ------------------------------------------------------------------
    // Register writes and hardware updates
    // ------------------------------------------------------------------
    always_comb begin
        syncCtrl_nxt   = syncCtrl_r;
        fastSetup_nxt  = fastSetup_r;
        upperLow_nxt   = upperLow_r;
        upperHigh_nxt  = upperHigh_r;
        lowerLow_nxt   = lowerLow_r;
        lowerHigh_nxt  = lowerHigh_r;
        dcCtrl_nxt     = dcCtrl_r;
        serialCtrl_nxt = serialCtrl_r;
        monCtrl_nxt    = monCtrl_r;
        window0_nxt    = window0_r;
        window1_nxt    = window1_r;
        window2_nxt    = window2_r;
        // Divider aligned once: drop its sync enable so later pulses are ignored
        if (dividerAligned) begin
            syncCtrl_nxt[MDC_SYNC_DIV_EN] = 1'b0;
        end
        // A software write in the same cycle wins over the self-clear
        if (regWrEn) begin
            case (regAddr)
                MDC_OFS_SYNC_GATE_CONTROL:   syncCtrl_nxt   = regWrData & MDC_MSK_SYNC;
                MDC_OFS_FAST_DETECT_SETUP:   fastSetup_nxt  = regWrData & MDC_MSK_FAST;
                MDC_OFS_UPPER_LIMIT_LOW:     upperLow_nxt   = regWrData & MDC_MSK_FULL;
                MDC_OFS_UPPER_LIMIT_HIGH:    upperHigh_nxt  = regWrData & MDC_MSK_LIMIT_HIGH;
                MDC_OFS_LOWER_LIMIT_LOW:     lowerLow_nxt   = regWrData & MDC_MSK_FULL;
                MDC_OFS_LOWER_LIMIT_HIGH:    lowerHigh_nxt  = regWrData & MDC_MSK_LIMIT_HIGH;
                MDC_OFS_OFFSET_REMOVAL_CTRL: dcCtrl_nxt     = regWrData & MDC_MSK_OFFSET;
                MDC_OFS_SERIAL_OUT_CONTROL:  serialCtrl_nxt = regWrData & MDC_MSK_SERIAL;
                MDC_OFS_MONITOR_CONTROL:     monCtrl_nxt    = regWrData & MDC_MSK_MONITOR;
                MDC_OFS_WINDOW_LEN_0:        window0_nxt    = regWrData;
                MDC_OFS_WINDOW_LEN_1:        window1_nxt    = regWrData;
                MDC_OFS_WINDOW_LEN_2:        window2_nxt    = regWrData;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------------
    always_comb begin
        dcEstA_nxt  = dcEstA_r;
        dcEstB_nxt  = dcEstB_r;
        resultA_nxt = resultA_r;
        // Freeze holds the last dc value computed
        if (!dcCtrl_r[MDC_DC_FREEZE]) begin
            dcEstA_nxt = status.dcEstA;
            dcEstB_nxt = status.dcEstB;
        end
        if (status.resultValid) begin
            resultA_nxt = status.resultA;
        end
    end

    // ------------------------------------------------------------------
    // Threshold compare
    // ------------------------------------------------------------------
    always_comb begin
        upperLimit    = {upperHigh_r[4:0], upperLow_r};
        lowerLimit    = {lowerHigh_r[4:0], lowerLow_r};
        upperFlag_nxt = sampleMag > upperLimit;
        lowerFlag_nxt = sampleMag < lowerLimit;
    end

    // ------------------------------------------------------------------
    // Read mux; registered, one cycle after the address
    // ------------------------------------------------------------------
    always_comb begin
        case (regAddr)
            MDC_OFS_SYNC_GATE_CONTROL:   regRdData_nxt = syncCtrl_r;
            MDC_OFS_FAST_DETECT_SETUP:   regRdData_nxt = fastSetup_r;
            MDC_OFS_UPPER_LIMIT_LOW:     regRdData_nxt = upperLow_r;
            MDC_OFS_UPPER_LIMIT_HIGH:    regRdData_nxt = upperHigh_r;
            MDC_OFS_LOWER_LIMIT_LOW:     regRdData_nxt = lowerLow_r;
            MDC_OFS_LOWER_LIMIT_HIGH:    regRdData_nxt = lowerHigh_r;
            MDC_OFS_OFFSET_REMOVAL_CTRL: regRdData_nxt = dcCtrl_r;
            MDC_OFS_OFFSET_EST_A_LOW:    regRdData_nxt = dcEstA_r[7:0];
            MDC_OFS_OFFSET_EST_A_HIGH:   regRdData_nxt = {2'h0, dcEstA_r[13:8]};
            MDC_OFS_OFFSET_EST_B_LOW:    regRdData_nxt = dcEstB_r[7:0];
            MDC_OFS_OFFSET_EST_B_HIGH:   regRdData_nxt = {2'h0, dcEstB_r[13:8]};
            MDC_OFS_SERIAL_OUT_CONTROL:  regRdData_nxt = serialCtrl_r;
            MDC_OFS_MONITOR_CONTROL:     regRdData_nxt = monCtrl_r;
            MDC_OFS_WINDOW_LEN_0:        regRdData_nxt = window0_r;
            MDC_OFS_WINDOW_LEN_1:        regRdData_nxt = window1_r;
            MDC_OFS_WINDOW_LEN_2:        regRdData_nxt = window2_r;
            MDC_OFS_RESULT_A_0:          regRdData_nxt = resultA_r[7:0];
            MDC_OFS_RESULT_A_1:          regRdData_nxt = resultA_r[15:8];
            default:                     regRdData_nxt = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncCtrl_r             <= MDC_RST_ZERO;
            fastSetup_r            <= MDC_RST_ZERO;
            upperLow_r             <= MDC_RST_ZERO;
            upperHigh_r            <= MDC_RST_ZERO;
            lowerLow_r             <= MDC_RST_ZERO;
            lowerHigh_r            <= MDC_RST_ZERO;
            dcCtrl_r               <= MDC_RST_ZERO;
            serialCtrl_r           <= MDC_RST_SERIAL_OUT;
            monCtrl_r              <= MDC_RST_ZERO;
            window0_r              <= MDC_RST_WINDOW_LEN0;
            window1_r              <= MDC_RST_ZERO;
            window2_r              <= MDC_RST_ZERO;
            dcEstA_r               <= 14'h0000;
            dcEstB_r               <= 14'h0000;
            resultA_r              <= 16'h0000;
            regRdData              <= 8'h00;
            upperLimitFlag         <= 1'b0;
            lowerLimitFlag         <= 1'b0;
            monitorSerialClockTick <= 1'b0;
            cfg                    <= '0;
        end else begin
            syncCtrl_r             <= syncCtrl_nxt;
            fastSetup_r            <= fastSetup_nxt;
            upperLow_r             <= upperLow_nxt;
            upperHigh_r            <= upperHigh_nxt;
            lowerLow_r             <= lowerLow_nxt;
            lowerHigh_r            <= lowerHigh_nxt;
            dcCtrl_r               <= dcCtrl_nxt;
            serialCtrl_r           <= serialCtrl_nxt;
            monCtrl_r              <= monCtrl_nxt;
            window0_r              <= window0_nxt;
            window1_r              <= window1_nxt;
            window2_r              <= window2_nxt;
            dcEstA_r               <= dcEstA_nxt;
            dcEstB_r               <= dcEstB_nxt;
            resultA_r              <= resultA_nxt;
            regRdData              <= regRdData_nxt;
            upperLimitFlag         <= upperFlag_nxt;
            lowerLimitFlag         <= lowerFlag_nxt;
            monitorSerialClockTick <= tickRaw;
            cfg.fastDetectEn       <= fastSetup_nxt[0];
            cfg.fastDetectMode     <= fastSetup_nxt[3:1];
            cfg.dcFreeze           <= dcCtrl_nxt[MDC_DC_FREEZE];
            cfg.dcBandwidth        <= dcCtrl_nxt[MDC_DC_BW_LSB +: 4];
            cfg.dcPathEn           <= dcCtrl_nxt[MDC_DC_PATH_EN];
            cfg.dcMonitorEn        <= dcCtrl_nxt[MDC_DC_MON_EN];
            cfg.rmsOutEn           <= serialCtrl_nxt[MDC_SO_RMS_EN];
            cfg.peakOutEn          <= serialCtrl_nxt[MDC_SO_PEAK_EN];
            cfg.crossOutEn         <= serialCtrl_nxt[MDC_SO_CROSS_EN];
            cfg.serialSleep        <= serialCtrl_nxt[MDC_SO_SLEEP];
            cfg.serialOutEn        <= serialCtrl_nxt[MDC_SO_EN];
            cfg.complexMode        <= monCtrl_nxt[MDC_MC_COMPLEX];
            cfg.msMode             <= monCtrl_nxt[MDC_MC_MS_MODE];
            cfg.monitorMode        <= monCtrl_nxt[MDC_MC_MODE_LSB +: 2];
            cfg.monitorEn          <= monCtrl_nxt[MDC_MC_EN];
            cfg.windowLen          <= {window2_nxt, window1_nxt, window0_nxt};
        end
    end
endmodule // mdc_regs
`default_nettype wire

/* File: testbench/mdc_regs_sva.sv */
// Checker: assertions on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module mdc_regs_sva
    import mdc_pkg::*;
(
    // Clock, reset, register port
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              regWrEn,
    input wire logic [11:0]       regAddr,
    input wire logic [7:0]        regWrData,
    // Datapath and events
    input wire logic [12:0]       sampleMag,
    input wire mdc_pkg::mdc_cfg_t cfg,
    input wire logic              upperLimitFlag,
    input wire logic              lowerLimitFlag,
    input wire logic              monitorSync,
    input wire logic              dividerSync,
    input wire logic              monitorSerialClockTick
);
    logic [7:0]  syM_r, seM_r;
    logic [12:0] upM_r, loM_r;
    // Mirrors of the registers that gate the events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syM_r <= 8'h00;
            seM_r <= 8'h04;
            upM_r <= 13'h0000;
            loM_r <= 13'h0000;
        end else if (regWrEn) begin
            case (regAddr)
                12'h100: syM_r <= regWrData;
                12'h111: seM_r <= regWrData;
                12'h106: upM_r[7:0] <= regWrData;
                12'h107: upM_r[12:8] <= regWrData[4:0];
                12'h108: loM_r[7:0] <= regWrData;
                12'h109: loM_r[12:8] <= regWrData[4:0];
                default: ;
            endcase
        end else if (dividerSync && syM_r[2]) begin
            // Next-sync-only: the divider enable drops after its one accepted pulse
            syM_r[1] <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_UPPER: assert property (upperLimitFlag == ($past(sampleMag) > $past(upM_r)))
        else $error("upper flag wrong");
    AST_LOWER: assert property (lowerLimitFlag == ($past(sampleMag) < $past(loM_r)))
        else $error("lower flag wrong");
    AST_MON_GATE: assert property (monitorSync |-> $past(syM_r[7] && syM_r[0]))
        else $error("monitor sync not enabled");
    AST_DIV_GATE: assert property (dividerSync |-> $past(syM_r[1] && syM_r[0]))
        else $error("divider sync not enabled");
    AST_SYNC_PULSE: assert property (monitorSync || dividerSync |=> !monitorSync && !dividerSync)
        else $error("sync pulse too long");
    AST_TICK_OFF: assert property (monitorSerialClockTick |-> $past(seM_r[0], 2) && $past(seM_r[3:2], 2) != 2'h0)
        else $error("tick while off");
    AST_TICK_DIV8: assert property (monitorSerialClockTick && seM_r[3:2] == 2'h3 |=> !monitorSerialClockTick [*7])
        else $error("divide by eight spacing");
    AST_CFG_DC: assert property (regWrEn && regAddr == 12'h10C |=>
        {cfg.dcFreeze, cfg.dcBandwidth, cfg.dcPathEn, cfg.dcMonitorEn} == $past(regWrData[6:0]))
        else $error("dc control not applied");
    cover property (monitorSync);
    cover property (dividerSync && syM_r[2]);
    cover property (upperLimitFlag);
endmodule // mdc_regs_sva
bind mdc_regs mdc_regs_sva i_sva (.clk, .rst_n, .regWrEn, .regAddr, .regWrData, .sampleMag, .cfg,
    .upperLimitFlag, .lowerLimitFlag, .monitorSync, .dividerSync, .monitorSerialClockTick);
`default_nettype wire

/* File: testbench/mdc_regs_test.sv */
// Testbench: register access, thresholds, sync gating and serial ticks
`timescale 1ns/10ps
`default_nettype none
module mdc_regs_test;
    import mdc_pkg::*;
    logic        clk, rst_n, regWrEn, syncPin, upF, loF, monS, divS, tick;
    logic [11:0] regAddr;
    logic [7:0]  regWrData, rdData;
    logic [12:0] sampleMag;
    mdc_status_t status;
    mdc_cfg_t    cfg;
    int          errorCnt, samplesChecked, monCnt, divCnt, tickCnt, i;
    logic [7:0]  rwA [12] = '{8'h00, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0C, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    logic [7:0]  rwR [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h40, 8'h00, 8'h00};
    logic [7:0]  rwM [12] = '{8'h87, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h7F, 8'h7F, 8'h8F, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0]  roA [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h16, 8'h17, 8'h01};
    logic [7:0]  roE [7] = '{8'hBC, 8'h2A, 8'h34, 8'h12, 8'hEF, 8'hBE, 8'h00};
    logic [7:0]  syV [4] = '{8'h00, 8'h86, 8'h83, 8'h07};
    logic [7:0]  syE [4] = '{8'h00, 8'h00, 8'h22, 8'h01};
    logic [12:0] magV [4] = '{13'h1001, 13'h1000, 13'h0100, 13'h00FF};
    logic [7:0]  flgV [4] = '{8'h02, 8'h00, 8'h00, 8'h01};
    logic [7:0]  tkV [5] = '{8'h00, 8'h18, 8'h0C, 8'h06, 8'h00};
    mdc_regs i_dut (.clk, .rst_n, .regWrEn, .regAddr, .regWrData, .regRdData(rdData), .syncPin, .sampleMag,
        .status, .cfg, .upperLimitFlag(upF), .lowerLimitFlag(loF), .monitorSync(monS), .dividerSync(divS),
        .monitorSerialClockTick(tick));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        monCnt += monS;
        divCnt += divS;
        tickCnt += tick;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        repeat (2) @(negedge clk);
        check(rdData, e);
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatched %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300us;
        errorCnt++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        regWrEn = 1'b0;
        regAddr = 12'h000;
        regWrData = 8'h00;
        syncPin = 1'b0;
        sampleMag = 13'h0000;
        status = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 12; i++) rd({4'h1, rwA[i]}, rwR[i]);
        check({cfg.rmsOutEn, cfg.peakOutEn, cfg.crossOutEn}, 16'h0000);
        for (i = 0; i < 12; i++) wr({4'h1, rwA[i]}, 8'hFF);
        for (i = 0; i < 12; i++) rd({4'h1, rwA[i]}, rwM[i]);
        check({cfg.rmsOutEn, cfg.peakOutEn, cfg.crossOutEn}, 16'h0007);
        wr(12'h10C, 8'h00);
        status = '{dcEstA: 14'h2ABC, dcEstB: 14'h1234, resultA: 16'hBEEF, resultValid: 1'b1};
        @(negedge clk);
        status.resultValid = 1'b0;
        wr(12'h10D, 8'h55);
        wr(12'h101, 8'h55);
        for (i = 0; i < 7; i++) rd({4'h1, roA[i]}, roE[i]);
        wr(12'h10C, 8'h40);
        status.dcEstA = 14'h0111;
        rd(12'h10D, 8'hBC);
        wr(12'h106, 8'h00);
        wr(12'h107, 8'h10);
        wr(12'h108, 8'h00);
        wr(12'h109, 8'h01);
        for (i = 0; i < 4; i++) begin
            sampleMag = magV[i];
            repeat (3) @(negedge clk);
            check({upF, loF}, flgV[i]);
        end
        for (i = 0; i < 4; i++) begin
            wr(12'h100, syV[i]);
            monCnt = 0;
            divCnt = 0;
            repeat (2) begin
                syncPin = 1'b1;
                repeat (6) @(negedge clk);
                syncPin = 1'b0;
                repeat (6) @(negedge clk);
            end
            check(monCnt * 16 + divCnt, syE[i]);
        end
        rd(12'h100, 8'h05);
        for (i = 0; i < 5; i++) begin
            wr(12'h111, 8'h00);
            wr(12'h111, serV(i));
            repeat (8) @(negedge clk);
            tickCnt = 0;
            repeat (48) @(negedge clk);
            check(tickCnt, tkV[i]);
        end
        print_verdict();
    end
    function automatic logic [7:0] serV(input int k);
        return (k == 4) ? 8'h0C : 8'(k * 4 + 1);
    endfunction
endmodule // mdc_regs_test
`default_nettype wire
